// ---- design/ics_pkg.sv ----
// Constants, field layouts and state codes for the conversion sequencer.
// Assumes a 12-input converter core with a 10-bit result.
package ics_pkg;

  // ----------------------------------------------------------------
  // Channel map and scan figures
  // ----------------------------------------------------------------
  localparam logic [3:0] ICS_TOP_CH = 4'hB;
  localparam logic [3:0] ICS_REF_TOP_CH = 4'hA;
  localparam logic [3:0] ICS_UPPER_CH = 4'h6;
  localparam logic [3:0] ICS_REPEAT_CNT = 4'h8;
  localparam int ICS_MEM_DEPTH = 12;
  localparam logic [1:0] ICS_SAMPLE_DLY = 2'h2;
  localparam logic [3:0] ICS_BYTE_BITS = 4'h8;

  localparam logic [1:0] ICS_SCAN_UP = 2'h0;
  localparam logic [1:0] ICS_SCAN_REP = 2'h1;
  localparam logic [1:0] ICS_SCAN_UPPER = 2'h2;
  localparam logic [1:0] ICS_SCAN_ONE = 2'h3;

  // ----------------------------------------------------------------
  // Written bytes: bit 7 tells setup from configuration
  // ----------------------------------------------------------------
  localparam int ICS_KIND_BIT = 7;

  typedef struct packed {
    logic [2:0] ref_sel;
    logic clk_ext;
    logic bipolar;
  } ics_setup_s;

  typedef struct packed {
    logic [1:0] scan;
    logic [3:0] chan;
    logic single;
  } ics_config_s;

  localparam ics_setup_s ICS_SETUP_RST = '{ref_sel: 3'h0, clk_ext: 1'h0,
                                           bipolar: 1'h0};
  localparam ics_config_s ICS_CONFIG_RST = '{scan: ICS_SCAN_ONE,
                                             chan: 4'h0, single: 1'h1};

  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ICS_IDLE = 7'h01,
    ICS_ADDR = 7'h02,
    ICS_ACK = 7'h04,
    ICS_WRITE = 7'h08,
    ICS_CONV = 7'h10,
    ICS_READ = 7'h20,
    ICS_RACK = 7'h40
  } ics_state_e;

endpackage

// ---- design/ics_seq.sv ----
// Two-wire slave that sequences conversions of a 12-input 10-bit core.
// Assumes an open-drain SCL/SDA pair outside and a converter core on
// ref_clk that answers adc_start with adc_done and offset-binary data.
//
// Operation
// - Clock-select one makes SCL the conversion clock
// - SCL mode: track at ninth rise, sample two later
// - SCL mode: data right after four high fillers
// - SCL mode converts read after read until not-acknowledge
// - Two-bit scan field picks the scan pattern
// - Shared pin as reference caps scan at ten
// - Internal mode: results stored, returned in order, six-high-bit first byte
// - Master acknowledges bytes; withheld acknowledge ends transfer
// - Stored results readable only through a conversion read
// - Power-up: single-ended unipolar input zero, supply reference
// - Analog circuits power down whenever idle
// - STOP, not-acknowledge, restart idle; internal mode self-shutdown
// - Internal results kept until a later conversion read overwrites them
// - Matching address byte powers the circuits up
// - Three-bit reference field decodes source and pin
// - Reference stays on; its output floats in shutdown
// - Straight binary unipolar, two's complement bipolar
// - Internal mode holds SCL low while converting
// - Clock-select cleared at power-up
// - Scan codes: up, repeat eight, upper, single
// - Not-acknowledge releases SDA
`timescale 1ns/1ns
module ics_seq
  import ics_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic adc_start,
  output logic [3:0] adc_channel,
  output logic adc_single_ended,
  output logic analog_on,
  output logic ref_on,
  output logic ref_out_en,
  output logic ref_pin_input
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] seq_first(input ics_config_s c);
    seq_first = (c.scan == ICS_SCAN_UPPER) ? ICS_UPPER_CH : 4'h0;
  endfunction

  function automatic logic [3:0] seq_count(input ics_config_s c,
                                           input logic pin_ref,
                                           input logic ext);
    logic [3:0] lim;
    logic [3:0] last;
    lim = pin_ref ? ICS_REF_TOP_CH : ICS_TOP_CH;
    last = (c.chan > lim) ? lim : c.chan;
    if (last < seq_first(c)) begin
      last = seq_first(c);
    end
    case (c.scan)
      ICS_SCAN_UP, ICS_SCAN_UPPER: seq_count = last - seq_first(c) + 4'h1;
      ICS_SCAN_REP: seq_count = ext ? 4'h1 : ICS_REPEAT_CNT;
      default: seq_count = 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] seq_chan(input ics_config_s c,
                                          input logic [3:0] idx);
    if (c.scan == ICS_SCAN_UP || c.scan == ICS_SCAN_UPPER) begin
      seq_chan = seq_first(c) + idx;
    end else begin
      seq_chan = c.chan;
    end
  endfunction

  function automatic logic [9:0] coded(input logic bip,
                                       input logic [9:0] d);
    coded = bip ? {~d[9], d[8:0]} : d;
  endfunction

  // Bit n of the first or second byte of one result word
  function automatic logic out_bit(input logic ext, input logic half,
                                   input logic [2:0] n,
                                   input logic [9:0] d);
    logic [15:0] w;
    w = ext ? {4'hF, d, 2'h3} : {6'h3F, d};
    out_bit = half ? w[{1'h0, n}] : w[{1'h1, n}];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_m_r <= 1'h1;
      scl_s_r <= 1'h1;
      scl_d_r <= 1'h1;
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  logic rise, fall, start_c, stop_c;
  assign rise = scl_s_r & ~scl_d_r;
  assign fall = ~scl_s_r & scl_d_r;
  assign start_c = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_c = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  ics_state_e state_r, state_nxt;
  ics_setup_s setup_r, setup_nxt;
  ics_config_s config_r, config_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic rw_r, rw_nxt;
  logic half_r, half_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [3:0] rd_ptr_r, rd_ptr_nxt;
  logic conv_wait_r, conv_wait_nxt;
  logic [1:0] samp_cd_r, samp_cd_nxt;
  logic [9:0] res_r, res_nxt;
  logic [9:0] mem_r [ICS_MEM_DEPTH];
  logic [9:0] mem_nxt [ICS_MEM_DEPTH];
  logic scl_oe_n_r, scl_oe_n_nxt;
  logic sda_oe_n_r, sda_oe_n_nxt;
  logic adc_start_r, adc_start_nxt;
  logic [3:0] adc_channel_r, adc_channel_nxt;
  logic single_r, single_nxt;
  logic analog_on_r, analog_on_nxt;
  logic ref_on_r, ref_on_nxt;
  logic ref_out_en_r, ref_out_en_nxt;
  logic ref_pin_input_r, ref_pin_input_nxt;
  logic pin_low_r;

  logic ext, pin_ref;
  logic [3:0] total;
  logic [9:0] cur_data;
  assign ext = setup_r.clk_ext;
  assign pin_ref = setup_r.ref_sel[1];
  assign total = seq_count(config_r, pin_ref, ext);
  assign cur_data = ext ? res_r : mem_r[rd_ptr_r];

  always_comb begin
    state_nxt = state_r;
    setup_nxt = setup_r;
    config_nxt = config_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    rw_nxt = rw_r;
    half_nxt = half_r;
    idx_nxt = idx_r;
    rd_ptr_nxt = rd_ptr_r;
    conv_wait_nxt = conv_wait_r;
    samp_cd_nxt = samp_cd_r;
    res_nxt = res_r;
    mem_nxt = mem_r;
    scl_oe_n_nxt = scl_oe_n_r;
    sda_oe_n_nxt = sda_oe_n_r;
    adc_start_nxt = 1'h0;
    adc_channel_nxt = adc_channel_r;
    analog_on_nxt = analog_on_r;

    // SCL-clocked sampling two rises after tracking starts
    if (rise && samp_cd_r != 2'h0) begin
      samp_cd_nxt = samp_cd_r - 2'h1;
      if (samp_cd_r == 2'h1) begin
        adc_start_nxt = 1'h1;
        adc_channel_nxt = seq_chan(config_r, idx_r);
      end
    end
    if (adc_done && ext) begin
      res_nxt = coded(setup_r.bipolar, adc_data);
    end

    if (stop_c || start_c) begin
      // Either condition idles the analog side; STOP idles the link, START goes to the address phase
      state_nxt = stop_c ? ICS_IDLE : ICS_ADDR;
      cnt_nxt = 4'h0;
      samp_cd_nxt = 2'h0;
      sda_oe_n_nxt = 1'h1;
      scl_oe_n_nxt = 1'h1;
      analog_on_nxt = 1'h0;
    end else begin
      case (state_r)
        ICS_ADDR, ICS_WRITE: begin
          if (rise) begin
            shift_nxt = {shift_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == ICS_BYTE_BITS) begin
            cnt_nxt = 4'h0;
            state_nxt = ICS_ACK;
            sda_oe_n_nxt = 1'h0;
            if (state_r == ICS_WRITE) begin
              if (shift_r[ICS_KIND_BIT]) begin
                setup_nxt = ics_setup_s'(shift_r[6:2]);
              end else begin
                config_nxt = ics_config_s'(shift_r[6:0]);
              end
            end else if (shift_r[7:1] == SLAVE_ADDR) begin
              rw_nxt = shift_r[0];
              analog_on_nxt = 1'h1;
              idx_nxt = 4'h0;
              half_nxt = 1'h0;
              rd_ptr_nxt = 4'h0;
            end else begin
              state_nxt = ICS_IDLE;
              sda_oe_n_nxt = 1'h1;
            end
          end
        end
        ICS_ACK: begin
          if (rise) begin
            cnt_nxt = 4'h1;
            if (rw_r && ext) begin
              samp_cd_nxt = ICS_SAMPLE_DLY;
            end
          end else if (fall && cnt_r != 4'h0) begin
            cnt_nxt = 4'h0;
            sda_oe_n_nxt = 1'h1;
            if (!rw_r) begin
              state_nxt = ICS_WRITE;
            end else if (ext) begin
              state_nxt = ICS_READ;
            end else begin
              // Every read reconverts; no plain memory read exists
              state_nxt = ICS_CONV;
              scl_oe_n_nxt = 1'h0;
              conv_wait_nxt = 1'h0;
            end
          end
        end
        ICS_CONV: begin
          if (!conv_wait_r) begin
            adc_start_nxt = 1'h1;
            adc_channel_nxt = seq_chan(config_r, idx_r);
            conv_wait_nxt = 1'h1;
          end else if (adc_done) begin
            mem_nxt[idx_r] = coded(setup_r.bipolar, adc_data);
            conv_wait_nxt = 1'h0;
            if (idx_r == total - 4'h1) begin
              // First bit out is a filler one, so SDA stays released
              scl_oe_n_nxt = 1'h1;
              analog_on_nxt = 1'h0;
              state_nxt = ICS_READ;
            end else begin
              idx_nxt = idx_r + 4'h1;
            end
          end
        end
        ICS_READ: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == ICS_BYTE_BITS) begin
              cnt_nxt = 4'h0;
              sda_oe_n_nxt = 1'h1;
              state_nxt = ICS_RACK;
            end else begin
              // Bit 7 - cnt, which is the low three bits inverted
              sda_oe_n_nxt = out_bit(ext, half_r, ~cnt_r[2:0], cur_data);
            end
          end
        end
        ICS_RACK: begin
          if (rise) begin
            cnt_nxt = 4'h1;
            if (sda_s_r) begin
              // Not-acknowledge ends the transfer
              state_nxt = ICS_IDLE;
              analog_on_nxt = 1'h0;
              samp_cd_nxt = 2'h0;
            end else if (half_r && ext) begin
              idx_nxt = (idx_r + 4'h1 == total) ? 4'h0
                                                  : idx_r + 4'h1;
              samp_cd_nxt = ICS_SAMPLE_DLY;
            end else if (half_r) begin
              rd_ptr_nxt = (rd_ptr_r + 4'h1 == total) ? 4'h0
                                                        : rd_ptr_r + 4'h1;
            end
          end else if (fall && cnt_r != 4'h0) begin
            cnt_nxt = 4'h0;
            half_nxt = ~half_r;
            state_nxt = ICS_READ;
            // Lead bit of the next byte must stand before its first rise
            sda_oe_n_nxt = out_bit(ext, ~half_r, 3'h7, cur_data);
          end
        end
        ICS_IDLE: begin
          sda_oe_n_nxt = 1'h1;
          scl_oe_n_nxt = 1'h1;
        end
        default: begin
          state_nxt = ICS_IDLE;
        end
      endcase
    end

    single_nxt = config_r.single;
    // Internal reference follows activity unless kept on
    ref_on_nxt = setup_r.ref_sel[2] &
                 (setup_r.ref_sel[0] | analog_on_nxt);
    ref_out_en_nxt = setup_r.ref_sel[2] & setup_r.ref_sel[1] &
                     analog_on_nxt;
    ref_pin_input_nxt = ~setup_r.ref_sel[2] & setup_r.ref_sel[1];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ICS_IDLE;
      setup_r <= ICS_SETUP_RST;
      config_r <= ICS_CONFIG_RST;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'h0;
      half_r <= 1'h0;
      idx_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      conv_wait_r <= 1'h0;
      samp_cd_r <= 2'h0;
      res_r <= 10'h000;
      scl_oe_n_r <= 1'h1;
      sda_oe_n_r <= 1'h1;
      adc_start_r <= 1'h0;
      adc_channel_r <= 4'h0;
      single_r <= 1'h1;
      analog_on_r <= 1'h0;
      ref_on_r <= 1'h0;
      ref_out_en_r <= 1'h0;
      ref_pin_input_r <= 1'h0;
      pin_low_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      setup_r <= setup_nxt;
      config_r <= config_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      rw_r <= rw_nxt;
      half_r <= half_nxt;
      idx_r <= idx_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      conv_wait_r <= conv_wait_nxt;
      samp_cd_r <= samp_cd_nxt;
      res_r <= res_nxt;
      scl_oe_n_r <= scl_oe_n_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      adc_start_r <= adc_start_nxt;
      adc_channel_r <= adc_channel_nxt;
      single_r <= single_nxt;
      analog_on_r <= analog_on_nxt;
      ref_on_r <= ref_on_nxt;
      ref_out_en_r <= ref_out_en_nxt;
      ref_pin_input_r <= ref_pin_input_nxt;
      pin_low_r <= 1'h0;
    end
  end

  // Result memory has no reset: contents are undefined at power-up
  always_ff @(posedge ref_clk) begin
    mem_r <= mem_nxt;
  end

  assign scl_out = pin_low_r;
  assign sda_out = pin_low_r;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;
  assign adc_start = adc_start_r;
  assign adc_channel = adc_channel_r;
  assign adc_single_ended = single_r;
  assign analog_on = analog_on_r;
  assign ref_on = ref_on_r;
  assign ref_out_en = ref_out_en_r;
  assign ref_pin_input = ref_pin_input_r;

endmodule // ics_seq

// ---- dv/ics_seq_asserts.sv ----
// Pin-level checks on the conversion sequencer.
// Assumes the bind at the foot reaches every ics_seq instance.
`timescale 1ns/1ns
module ics_seq_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic adc_done,
  input wire logic adc_start,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic analog_on,
  input wire logic ref_on,
  input wire logic ref_out_en,
  input wire logic ref_pin_input
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ------------------------------------------------
  // Open-drain pins and stretching
  // ------------------------------------------------
  pins_low_a: assert property (
    !scl_out && !sda_out) else $error("pin data not low");
  stretch_on_a: assert property (
    !scl_oe_n |-> analog_on && sda_oe_n) else $error("bad stretch");
  stretch_from_ack_a: assert property (
    $fell(scl_oe_n) |-> !$past(sda_oe_n))
    else $error("stretch not begun at ack");
  stretch_end_a: assert property (
    $rose(scl_oe_n) |-> $past(adc_done) || $past(adc_done, 2))
    else $error("stretch ends without result");
  // Data held for a moment after each clock fall
  sda_hold_a: assert property (
    $fell(scl_in) |=> $stable(sda_oe_n)) else $error("sda moved at fall");
  // ------------------------------------------------
  // Conversion and reference
  // ------------------------------------------------
  one_start_a: assert property (
    adc_start |=> !adc_start) else $error("start held too long");
  convert_on_a: assert property (
    adc_start |-> analog_on) else $error("convert while powered down");
  ref_out_a: assert property (
    ref_out_en |-> analog_on && ref_on && !ref_pin_input)
    else $error("reference pin drive wrong");
endmodule // ics_seq_asserts

bind ics_seq ics_seq_asserts u_chk (.ref_clk, .rstn, .scl_in, .adc_done,
  .adc_start, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n, .analog_on,
  .ref_on, .ref_out_en, .ref_pin_input);

// ---- dv/ics_i2c_master.sv ----
// Two-wire bus master model, open-drain on SCL and SDA.
// Assumes the bench pulls both wires up and feeds back their level.
`timescale 1ns/1ns
module ics_i2c_master (
  input wire logic clk,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_drv,
  output logic sda_drv
);
  int stall = 0;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // ------------------------------------------------
  // Bus phases
  // ------------------------------------------------
  // Short levels keep every conversion far inside its droop limit
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // Also a repeated start
  task automatic start();
    @(posedge clk);
    sda_drv <= 1'b1;
    half();
    scl_drv <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl_drv <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk);
    sda_drv <= 1'b0;
    half();
    scl_drv <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask
  // Data moves one clock after the fall, never with it
  task automatic xbit(input logic b, output logic r);
    int n = 0;
    @(posedge clk);
    sda_drv <= b;
    half();
    scl_drv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (scl_w !== 1'b1 && n < 5000);
    if (n == 5000) stall++;
    half();
    r = sda_w;
    scl_drv <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ack_in, ack);
  endtask
endmodule // ics_i2c_master

// ---- dv/ics_seq_test.sv ----
// Self-checking bench for the conversion sequencer.
// Assumes pulled-up wires and a core stand-in that answers each
// start three clocks later with its channel in the top bits.
`timescale 1ns/1ns
module ics_seq_test;
  import ics_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A; // Arbitrary value
  logic ref_clk, rstn, adc_done, m_scl, m_sda;
  logic [9:0] adc_data;
  logic [3:0] adc_channel, cur;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, adc_start, adc_single_ended;
  logic analog_on, ref_on, ref_out_en, ref_pin_input;
  logic [3:0] log_q[$];
  logic [1:0] sc_t[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [3:0] ch_t[5] = '{4'h3, 4'h5, 4'h8, 4'h2, 4'hF};
  int n_mismatch = 0;
  int checks = 0;
  wire scl_w = m_scl & (scl_oe_n | scl_out);
  wire sda_w = m_sda & (sda_oe_n | sda_out);

  ics_seq #(.SLAVE_ADDR(ADDR)) uut (.ref_clk, .rstn, .scl_in(scl_w),
    .sda_in(sda_w), .adc_done, .adc_data, .scl_out, .scl_oe_n, .sda_out,
    .sda_oe_n, .adc_start, .adc_channel, .adc_single_ended, .analog_on,
    .ref_on, .ref_out_en, .ref_pin_input);
  ics_i2c_master m (.clk(ref_clk), .scl_w, .sda_w, .scl_drv(m_scl),
    .sda_drv(m_sda));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    if (adc_start) begin
      cur = adc_channel;
      log_q.push_back(cur);
      repeat (3) @(posedge ref_clk);
      adc_done <= 1'b1;
      adc_data <= {cur, 6'h25};
    end
  end
  // ------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [9:0] seen,
                     input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    logic [7:0] q;
    logic a;
    m.start();
    m.xbyte({ADDR, 1'b0}, 1'b1, q, a);
    chk("addr ack", a, 1'b0);
    m.xbyte(b, 1'b1, q, a);
    chk("byte ack", a, 1'b0);
    m.stop();
    m.half();
  endtask
  // One read: results beyond the scan length wrap to the first
  task automatic rd(input logic [1:0] sc, input logic [3:0] ch,
                    input logic cap, input logic bip, input logic ext,
                    input int more);
    logic [3:0] e[$];
    logic [9:0] d;
    logic [7:0] q;
    logic a;
    int lo;
    int hi;
    int n;
    hi = cap ? ICS_REF_TOP_CH : ICS_TOP_CH;
    hi = ch < hi ? ch : hi;
    lo = sc == ICS_SCAN_UP ? 0 : ICS_UPPER_CH;
    if (sc == ICS_SCAN_ONE || (ext && sc == ICS_SCAN_REP)) begin
      e.push_back(ch);
    end else if (sc == ICS_SCAN_REP) begin
      repeat (ICS_REPEAT_CNT) e.push_back(ch);
    end else begin
      for (int c = lo; c <= (hi > lo ? hi : lo); c++) e.push_back(4'(c));
    end
    n = e.size() + more;
    log_q.delete();
    m.start();
    m.xbyte({ADDR, 1'b1}, 1'b1, q, a);
    chk("addr ack", a, 1'b0);
    for (int k = 0; k < n; k++) begin
      d = {e[k % e.size()], 6'h25} ^ {bip, 9'h0};
      m.xbyte(8'hFF, 1'b0, q, a);
      chk("byte0", q, ext ? {4'hF, d[9:6]} : {6'h3F, d[9:8]});
      m.xbyte(8'hFF, k == n - 1, q, a);
      chk("byte1", q, ext ? {d[5:0], 2'h3} : d[7:0]);
      if (ext || k < e.size()) chk("chan", log_q[k], e[k % e.size()]);
    end
    m.half();
    chk("sda free", sda_oe_n, 1'b1);
    chk("power", analog_on, 1'b0);
    chk("count", 10'(log_q.size()), 10'(ext ? n : e.size()));
    m.stop();
  endtask
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] q;
    logic a;
    rstn = 1'b0;
    adc_done = 1'b0;
    adc_data = 10'h0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("oe", {sda_oe_n, scl_oe_n}, 2'h3);
    chk("on", {analog_on, ref_on, ref_out_en, ref_pin_input}, 4'h0);
    chk("single", adc_single_ended, 1'b1);
    m.start();
    m.xbyte({~ADDR, 1'b1}, 1'b1, q, a);
    chk("nak", a, 1'b1);
    chk("asleep", analog_on, 1'b0);
    m.stop();
    rd(2'h3, 4'h0, 1'b0, 1'b0, 1'b0, 1);
    for (int i = 0; i < 5; i++) begin
      wr({1'b0, sc_t[i], ch_t[i], 1'b1});
      rd(sc_t[i], ch_t[i], 1'b0, 1'b0, 1'b0, 1);
    end
    for (int s = 0; s < 8; s++) begin
      wr({1'b1, 3'(s), 4'h0});
      chk("ref", {ref_on, ref_out_en, ref_pin_input},
          {s[2] & s[0], 1'b0, s[2:1] == 2'h1});
    end
    wr({1'b0, 2'h0, 4'hB, 1'b1});
    rd(2'h0, 4'hB, 1'b1, 1'b0, 1'b0, 0);
    wr({1'b0, 2'h2, 4'hF, 1'b1});
    rd(2'h2, 4'hF, 1'b1, 1'b0, 1'b0, 0);
    wr({1'b1, 3'h7, 1'b0, 1'b1, 2'h0});
    wr({1'b0, 2'h3, 4'h4, 1'b1});
    rd(2'h3, 4'h4, 1'b1, 1'b1, 1'b0, 1);
    wr({1'b1, 3'h0, 1'b1, 1'b0, 2'h0});
    wr({1'b0, 2'h0, 4'h2, 1'b1});
    rd(2'h0, 4'h2, 1'b0, 1'b0, 1'b1, 2);
    wr({1'b0, 2'h1, 4'h7, 1'b1});
    rd(2'h1, 4'h7, 1'b0, 1'b0, 1'b1, 2);
    wr({1'b0, 2'h3, 4'h1, 1'b0});
    chk("diff", adc_single_ended, 1'b0);
    chk("stall", 10'(m.stall), 10'h0);
    tally_and_finish();
  end
  initial begin
    #1500000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // ics_seq_test
